// *** dv/cmirq_aggregator_tb.sv ***
`timescale 1ns/10ps
module cmirq_aggregator_tb;
  reg         ref_clk = 1'h0, resetn = 1'h0, reg_wr = 1'h0, reg_sel_enable = 1'h1, status_wr = 1'h0;
  reg         loss_clear = 1'h0, pin_source_sel = 1'h1, pin_other_source = 1'h0;
  reg  [15:0] reg_wdata = 16'h0000, status_wdata = 16'hFFFF;
  reg  [2:0]  loss_clear_mask = 3'h7;
  reg  [8:0]  ev = 9'h000;
  wire [1:0]  activity_event = ev[8:7];
  wire [2:0]  loss_detect = ev[6:4];
  wire        digital_loop_state_change_event = ev[3], digital_loop_hold_event = ev[2];
  wire        digital_loop_unlock_event = ev[1], analog_loop_unlock_event = ev[0];
  wire [15:0] irq_enable_mask_ff, irq_status_mirror_ff;
  wire        device_irq_ff, status_pin_ff, irq_seen;
  integer     n_fail = 0, comparisons = 0, i;
  always #12.5 ref_clk = ~ref_clk;
  cmirq_aggregator dut (.*);
  cmirq_host_model host (.ref_clk(ref_clk), .status_pin_ff(status_pin_ff), .irq_seen(irq_seen));
  task tick(input integer n); begin repeat (n) @(posedge ref_clk); #1; end endtask
  task wr(input [15:0] d); begin @(posedge ref_clk); reg_wr <= 1'h1; reg_wdata <= d; @(posedge ref_clk); reg_wr <= 1'h0; tick(4); end endtask
  // events drop first so the clear is not refused by a loss still in the synchroniser
  task quiet; begin @(posedge ref_clk); ev <= 9'h000; tick(3); @(posedge ref_clk); loss_clear <= 1'h1; @(posedge ref_clk); loss_clear <= 1'h0; tick(2); end endtask
  task chk(input [15:0] seen, input [15:0] exp, input string nm);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin n_fail = n_fail + 1; $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen); end
    end
  endtask
  task complete_run;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial
  begin
    tick(10); @(posedge ref_clk); resetn <= 1'h1; tick(2);
    chk(irq_enable_mask_ff, 16'h0000, "enable reset");
    chk(irq_status_mirror_ff, 16'h0070, "loss reset");
    @(posedge ref_clk); ev <= 9'h010; status_wr <= 1'h1; tick(3);
    @(posedge ref_clk); loss_clear <= 1'h1; @(posedge ref_clk); loss_clear <= 1'h0; status_wr <= 1'h0; tick(2);
    chk(irq_status_mirror_ff, 16'h0010, "clear held");
    quiet;
    for (i = 0; i < 9; i = i + 1)
    begin
      wr(16'h81FF ^ (16'h0001 << i));
      @(posedge ref_clk); ev <= 9'h001 << i; tick(5);
      chk(irq_status_mirror_ff, 16'h0001 << i, "flag masked");
      chk(irq_seen, 16'h0000, "pin masked");
      wr(16'h8000 | (16'h0001 << i));
      chk(irq_enable_mask_ff, 16'h8000 | (16'h0001 << i), "enable readback");
      chk({device_irq_ff, irq_status_mirror_ff[15], irq_seen}, 16'h0007, "irq on");
      wr(16'h0001 << i);
      chk(irq_seen, 16'h0000, "global off");
      quiet;
    end
    @(posedge ref_clk); pin_source_sel <= 1'h0; pin_other_source <= 1'h1; tick(3);
    chk(irq_seen, 16'h0001, "other source");
    complete_run;
  end
endmodule // cmirq_aggregator_tb

// *** dv/cmirq_host_model.sv ***
`timescale 1ns/10ps
module cmirq_host_model
(
  input  wire ref_clk,
  input  wire status_pin_ff,
  output reg  irq_seen
);
  // level sampled per clock; a pulse shorter than one cycle would be missed
  always @(posedge ref_clk) irq_seen <= status_pin_ff;
endmodule // cmirq_host_model

// *** dv/cmirq_sva.sv ***
`timescale 1ns/10ps
module cmirq_sva
(
  input wire        ref_clk,
  input wire        resetn,
  input wire        pin_source_sel,
  input wire        pin_other_source,
  input wire [15:0] irq_enable_mask_ff,
  input wire [15:0] irq_status_mirror_ff,
  input wire        device_irq_ff,
  input wire        status_pin_ff
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_sum; irq_status_mirror_ff[15] == |(irq_status_mirror_ff[8:0] & $past(irq_enable_mask_ff[8:0])); endproperty
  a_sum: assert property (p_sum) else $error("summary wrong");
  property p_irq; device_irq_ff == (irq_status_mirror_ff[15] & $past(irq_enable_mask_ff[15])); endproperty
  a_irq: assert property (p_irq) else $error("irq wrong");
  property p_pin; pin_source_sel [*3] ##0 $stable(device_irq_ff) |-> status_pin_ff == device_irq_ff; endproperty
  a_pin: assert property (p_pin) else $error("pin wrong");
  property p_alt; !$past(pin_source_sel) |-> status_pin_ff == $past(pin_other_source); endproperty
  a_alt: assert property (p_alt) else $error("alternate pin source wrong");
  property p_gdis; !$past(irq_enable_mask_ff[15]) |-> !device_irq_ff; endproperty
  a_gdis: assert property (p_gdis) else $error("irq while global enable off");
  property p_rsv; irq_status_mirror_ff[14:9] == 6'h00 && irq_enable_mask_ff[14:12] == 3'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
  cover property (device_irq_ff);
  cover property (!pin_source_sel && status_pin_ff);
  cover property (irq_status_mirror_ff[15] && !device_irq_ff);
endmodule // cmirq_sva
bind cmirq_aggregator cmirq_sva sva_i (.*);

// *** src/cmirq_aggregator.v ***
`timescale 1ns/10ps
`include "cmirq_defines.vh"
// Notes on behaviour
// - summary flag is OR of nine status bits each ANDed with its enable bit
// - device interrupt is summary flag gated by the global enable
// - status pin carries the gated interrupt when its source select picks it
// - bit 8 mirrors complementary input activity event, gated by enable bit 8
// - bit 7 mirrors primary input activity event, gated by enable bit 7
// - bit 6 mirrors crystal input loss event, gated by enable bit 6
// - bit 5 mirrors complementary input loss event, gated by enable bit 5
// - bit 4 mirrors primary input loss event, gated by enable bit 4
// - bit 3 mirrors digital loop state change event, gated by enable bit 3
// - bit 2 mirrors digital loop hold entry event, gated by enable bit 2
// - bit 1 mirrors digital loop unlock event, gated by enable bit 1
// - bit 0 mirrors analog loop unlock event, gated by enable bit 0
// - all enables, global included, reset to zero
// - loss flags set from reset and while loss persists; a loss_clear pulse clears those its mask names
module cmirq_aggregator
(
  input  wire        ref_clk,
  input  wire        resetn,
  input  wire        reg_wr,
  input  wire        reg_sel_enable,
  input  wire [15:0] reg_wdata,
  input  wire        status_wr,
  input  wire [15:0] status_wdata,
  input  wire        loss_clear,
  input  wire [2:0]  loss_clear_mask,
  input  wire [2:0]  loss_detect,
  input  wire [1:0]  activity_event,
  input  wire        digital_loop_state_change_event,
  input  wire        digital_loop_hold_event,
  input  wire        digital_loop_unlock_event,
  input  wire        analog_loop_unlock_event,
  input  wire        pin_source_sel,
  input  wire        pin_other_source,
  output reg  [15:0] irq_enable_mask_ff,
  output reg  [15:0] irq_status_mirror_ff,
  output reg         device_irq_ff,
  output reg         status_pin_ff
);

  reg  [2:0]  loss_sync1_ff;
  reg  [2:0]  loss_sync2_ff;
  reg         prim_loss_flag_ff;
  reg         comp_loss_flag_ff;
  reg         xtal_loss_flag_ff;
  reg  [1:0]  act_sync1_ff;
  reg  [1:0]  act_sync2_ff;
  reg  [2:0]  dloop_sync1_ff;
  reg  [2:0]  dloop_sync2_ff;
  reg         aloop_sync1_ff;
  reg         aloop_sync2_ff;
  reg  [15:0] nxt_status;
  reg  [8:0]  gated;
  reg         nxt_summary;
  reg         nxt_irq;
  reg         nxt_pin;
  wire        enable_wr;
  wire [2:0]  loss_clr;

  // one source bit counts toward the summary only while its gate is set
  function cmirq_gate_bit;
    input flag;
    input en;
    begin
      cmirq_gate_bit = flag & en;
    end
  endfunction

  // loss levels come from monitors in other clock domains
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      loss_sync1_ff <= `CMIRQ_LOS_RESET;
      loss_sync2_ff <= `CMIRQ_LOS_RESET;
    end
    else
    begin
      loss_sync1_ff <= loss_detect;
      loss_sync2_ff <= loss_sync1_ff;
    end
  end

  // activity flags are asynchronous levels, two flops before use
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      act_sync1_ff <= 2'h0;
      act_sync2_ff <= 2'h0;
    end
    else
    begin
      act_sync1_ff <= activity_event;
      act_sync2_ff <= act_sync1_ff;
    end
  end

  // digital loop events: state change, hold entry, unlock
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dloop_sync1_ff <= 3'h0;
      dloop_sync2_ff <= 3'h0;
    end
    else
    begin
      dloop_sync1_ff <= {digital_loop_state_change_event, digital_loop_hold_event, digital_loop_unlock_event};
      dloop_sync2_ff <= dloop_sync1_ff;
    end
  end

  // analog loop unlock, two flops like every other source
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aloop_sync1_ff <= 1'b0;
      aloop_sync2_ff <= 1'b0;
    end
    else
    begin
      aloop_sync1_ff <= analog_loop_unlock_event;
      aloop_sync2_ff <= aloop_sync1_ff;
    end
  end

  // a clear pulse only touches the flags that its mask names
  assign loss_clr = loss_clear ? loss_clear_mask : 3'h0;

  // set wins over clear, so a persisting loss cannot be cleared
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      prim_loss_flag_ff <= `CMIRQ_LOS_FLAG_RESET;
    else
      prim_loss_flag_ff <= loss_sync2_ff[0] | (prim_loss_flag_ff & ~loss_clr[0]);
  end

  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      comp_loss_flag_ff <= `CMIRQ_LOS_FLAG_RESET;
    else
      comp_loss_flag_ff <= loss_sync2_ff[1] | (comp_loss_flag_ff & ~loss_clr[1]);
  end

  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      xtal_loss_flag_ff <= `CMIRQ_LOS_FLAG_RESET;
    else
      xtal_loss_flag_ff <= loss_sync2_ff[2] | (xtal_loss_flag_ff & ~loss_clr[2]);
  end

  always @*
  begin
    nxt_status = 16'h0000;
    nxt_status[`CMIRQ_COMP_ACT_BIT]  = act_sync2_ff[1];
    nxt_status[`CMIRQ_PRIM_ACT_BIT]  = act_sync2_ff[0];
    nxt_status[`CMIRQ_XTAL_LOS_BIT]  = xtal_loss_flag_ff;
    nxt_status[`CMIRQ_COMP_LOS_BIT]  = comp_loss_flag_ff;
    nxt_status[`CMIRQ_PRIM_LOS_BIT]  = prim_loss_flag_ff;
    nxt_status[`CMIRQ_DL_STATE_BIT]  = dloop_sync2_ff[2];
    nxt_status[`CMIRQ_DL_HOLD_BIT]   = dloop_sync2_ff[1];
    nxt_status[`CMIRQ_DL_UNLOCK_BIT] = dloop_sync2_ff[0];
    nxt_status[`CMIRQ_AL_UNLOCK_BIT] = aloop_sync2_ff;
    gated[8] = cmirq_gate_bit(nxt_status[8], irq_enable_mask_ff[8]);
    gated[7] = cmirq_gate_bit(nxt_status[7], irq_enable_mask_ff[7]);
    gated[6] = cmirq_gate_bit(nxt_status[6], irq_enable_mask_ff[6]);
    gated[5] = cmirq_gate_bit(nxt_status[5], irq_enable_mask_ff[5]);
    gated[4] = cmirq_gate_bit(nxt_status[4], irq_enable_mask_ff[4]);
    gated[3] = cmirq_gate_bit(nxt_status[3], irq_enable_mask_ff[3]);
    gated[2] = cmirq_gate_bit(nxt_status[2], irq_enable_mask_ff[2]);
    gated[1] = cmirq_gate_bit(nxt_status[1], irq_enable_mask_ff[1]);
    gated[0] = cmirq_gate_bit(nxt_status[0], irq_enable_mask_ff[0]);
    nxt_summary = |gated;
    nxt_status[`CMIRQ_SUMMARY_BIT] = nxt_summary;
    nxt_irq = cmirq_gate_bit(nxt_summary, irq_enable_mask_ff[`CMIRQ_GLOBAL_BIT]);
    nxt_pin = (pin_source_sel == `CMIRQ_SEL_DEVICE_IRQ) ? nxt_irq : pin_other_source;
  end

  // reserved bits 14:12 stay zero; a write there is dropped
  assign enable_wr = reg_wr & reg_sel_enable;

  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      irq_enable_mask_ff <= `CMIRQ_ENABLE_RESET;
    else if (enable_wr)
      irq_enable_mask_ff <= reg_wdata & `CMIRQ_ENABLE_WMASK;
  end

  // status_wr and status_wdata are accepted and deliberately dropped
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      irq_status_mirror_ff <= 16'h0000;
    else
      irq_status_mirror_ff <= nxt_status;
  end

  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      device_irq_ff <= 1'b0;
    else
      device_irq_ff <= nxt_irq;
  end

  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      status_pin_ff <= 1'b0;
    else
      status_pin_ff <= nxt_pin;
  end

endmodule // cmirq_aggregator

// *** src/cmirq_defines.vh ***
`ifndef CMIRQ_DEFINES_VH
`define CMIRQ_DEFINES_VH
`define CMIRQ_REG_W          16
`define CMIRQ_SRC_N          9
`define CMIRQ_ENABLE_RESET   16'h0000
`define CMIRQ_ENABLE_WMASK   16'h8FFF
`define CMIRQ_GLOBAL_BIT     15
`define CMIRQ_SUMMARY_BIT    15
`define CMIRQ_COMP_ACT_BIT   8
`define CMIRQ_PRIM_ACT_BIT   7
`define CMIRQ_XTAL_LOS_BIT   6
`define CMIRQ_COMP_LOS_BIT   5
`define CMIRQ_PRIM_LOS_BIT   4
`define CMIRQ_DL_STATE_BIT   3
`define CMIRQ_DL_HOLD_BIT    2
`define CMIRQ_DL_UNLOCK_BIT  1
`define CMIRQ_AL_UNLOCK_BIT  0
`define CMIRQ_LOS_RESET      3'h7
`define CMIRQ_LOS_FLAG_RESET 1'h1
`define CMIRQ_SEL_DEVICE_IRQ 1'h1
`endif
